// file: rtl/wdsl_pkg.sv
// Package: constants for the watchdog timer with fuse-selected safety levels
// Functional notes
// - Counter advances on a separate 1 MHz oscillator tick, not the system clock; here the tick is divided down from REF_CLK.
// - Restart instruction sets the watchdog counter back to zero.
// - Counter also clears while disabled and on every chip reset.
// - Enabled counter reaching selected period without restart resets the whole chip.
// - Fuses give level: compat only is 0, neither is 1, always-on is 2.
// - Writing enable as one always enables, no unlock, at every level.
// - After reset watchdog is off at levels 0 and 1, on at level 2.
// - Control bits 7 to 5 are reserved and read as zero.
// - Change-unlock bit clears itself four system clocks after being written one.
// - Enable can be cleared only while change-unlock bit is one.
// - At level 2 every disable attempt is ignored, even a timed one.
// - Period select code gives 16K oscillator cycles, doubling per step to 2048K.
// - At level 0 period select may change at any time freely.
// - At level 1 period changes and disabling happen only inside an unlock window.
// - At level 2 the enable bit always reads one.
// - At level 2 period changes by timed sequence; written enable value ignored.
// - Time-out gives a one system clock reset pulse.
package wdsl_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] COUNT_OFFSET = 12'h004;
   localparam logic [7:0] CTRL_RESET_LVL01 = 8'h00;
   localparam logic [7:0] CTRL_RESET_LVL2 = 8'h08;
   localparam int RSVD_MSB = 7;
   localparam int RSVD_LSB = 5;
   localparam int UNLOCK_POS = 4;
   localparam int ENABLE_POS = 3;
   localparam int PERIOD_MSB = 2;
   localparam int PERIOD_LSB = 0;

   // ----------------------------------------------------------------
   // Safety levels
   // ----------------------------------------------------------------
   localparam logic [1:0] LEVEL_0 = 2'h0;
   localparam logic [1:0] LEVEL_1 = 2'h1;
   localparam logic [1:0] LEVEL_2 = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint REF_FREQ_HZ = 100_000_000;
   localparam longint OSC_FREQ_HZ = 1_000_000;
   localparam int OSC_DIV_CYCLES = int'(REF_FREQ_HZ / OSC_FREQ_HZ);
   localparam int DIV_W = 7;
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   localparam int BASE_PERIOD_OSC = 16384;
   localparam int COUNT_W = 21;
endpackage

// file: rtl/wdsl_watchdog.sv
// Watchdog timer with fuse safety levels, APB control and chip reset output
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module wdsl_watchdog #(
   parameter int BASE_PERIOD = wdsl_pkg::BASE_PERIOD_OSC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Processor and fuses
   input wire logic RESTART_INSTR,
   input wire logic LEGACY_COMPAT_FUSE,
   input wire logic ALWAYS_ON_FUSE,
   // Chip reset request
   output logic CHIP_RESET
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Last oscillator count of the selected period
   function automatic logic [20:0] period_limit(input logic [2:0] code);
      logic [31:0] full;
      full = (32'(BASE_PERIOD) << code) - 32'h0000_0001;
      return full[20:0];
   endfunction

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
      return addr == off;
   endfunction

   // ----------------------------------------------------------------
   // Oscillator tick
   // ----------------------------------------------------------------
   // The 1 MHz oscillator is an enable pulse from a divider, so the
   // counter shares the system clock domain and restart, clear and
   // period changes need no crossing: they act on the very next edge.
   localparam logic [6:0] DIV_LAST = 7'(wdsl_pkg::OSC_DIV_CYCLES - 1);
   logic [6:0] div_cnt;
   logic [6:0] next_div_cnt;
   logic tick;
   logic next_tick;

   always_comb begin
      next_div_cnt = div_cnt + 7'h01;
      next_tick = 1'b0;
      if (div_cnt == DIV_LAST) begin
         next_div_cnt = 7'h00;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         div_cnt <= 7'h00;
         tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick <= next_tick;
      end
   end

   // ----------------------------------------------------------------
   // Safety level
   // ----------------------------------------------------------------
   // Fuses are caught while reset is held; they are not expected to move.
   logic [1:0] level;
   logic [1:0] next_level;

   always_comb begin
      if (ALWAYS_ON_FUSE) begin
         next_level = wdsl_pkg::LEVEL_2;
      end else if (LEGACY_COMPAT_FUSE) begin
         next_level = wdsl_pkg::LEVEL_0;
      end else begin
         next_level = wdsl_pkg::LEVEL_1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         level <= next_level;
      end else begin
         level <= level;
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic setup;
   logic access;
   logic wr_ctrl;
   logic [7:0] wbyte;
   logic mapped;

   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && PREADY;
   assign mapped = hit(PADDR, wdsl_pkg::CTRL_OFFSET) || hit(PADDR, wdsl_pkg::COUNT_OFFSET);
   assign wr_ctrl = access && PWRITE && hit(PADDR, wdsl_pkg::CTRL_OFFSET);
   assign wbyte = PWDATA[7:0];

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic enable;
   logic [2:0] period;
   logic [2:0] unlock_cnt;
   logic unlock_open;
   logic next_enable;
   logic [2:0] next_period;
   logic [2:0] next_unlock_cnt;
   logic w_unlock;
   logic w_enable;
   logic wr_unlock;

   assign unlock_open = unlock_cnt != 3'h0;
   assign w_unlock = wbyte[wdsl_pkg::UNLOCK_POS];
   assign w_enable = wbyte[wdsl_pkg::ENABLE_POS];
   assign wr_unlock = wr_ctrl && w_unlock && w_enable;

   always_comb begin
      next_enable = enable;
      next_period = period;
      next_unlock_cnt = unlock_cnt;
      if (unlock_open) begin
         next_unlock_cnt = unlock_cnt - 3'h1;
      end
      if (wr_unlock) begin
         next_unlock_cnt = wdsl_pkg::UNLOCK_CYCLES;
      end
      if (wr_ctrl) begin
         if (w_enable) begin
            next_enable = 1'b1;
         end else if (unlock_open && level != wdsl_pkg::LEVEL_2) begin
            next_enable = 1'b0;
         end
         if (level == wdsl_pkg::LEVEL_0) begin
            next_period = wbyte[wdsl_pkg::PERIOD_MSB:wdsl_pkg::PERIOD_LSB];
         end else if (unlock_open && !w_unlock) begin
            // Second step of the timed sequence
            next_period = wbyte[wdsl_pkg::PERIOD_MSB:wdsl_pkg::PERIOD_LSB];
         end
      end
      if (level == wdsl_pkg::LEVEL_2) begin
         next_enable = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         enable <= ALWAYS_ON_FUSE;
         period <= wdsl_pkg::CTRL_RESET_LVL01[2:0];
         unlock_cnt <= 3'h0;
      end else begin
         enable <= next_enable;
         period <= next_period;
         unlock_cnt <= next_unlock_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter and time-out
   // ----------------------------------------------------------------
   logic [20:0] count;
   logic [20:0] next_count;
   logic next_chip_reset;
   logic expire;

   assign expire = enable && tick && !RESTART_INSTR && count == period_limit(period);

   always_comb begin
      next_count = count;
      next_chip_reset = 1'b0;
      if (!next_enable) begin
         next_count = 21'h00_0000;
      end else if (RESTART_INSTR) begin
         next_count = 21'h00_0000;
      end else if (expire) begin
         // Counter restarts too; the chip reset will clear it again anyway
         next_count = 21'h00_0000;
         next_chip_reset = 1'b1;
      end else if (tick) begin
         next_count = count + 21'h00_0001;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         count <= 21'h00_0000;
         CHIP_RESET <= 1'b0;
      end else begin
         count <= next_count;
         CHIP_RESET <= next_chip_reset;
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   // Zero wait states: the answer is prepared in the setup cycle.
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic [7:0] ctrl_view;

   assign ctrl_view = {3'h0, unlock_open, enable || level == wdsl_pkg::LEVEL_2, period};

   always_comb begin
      next_pready = setup;
      next_pslverr = setup && !mapped;
      next_prdata = 32'h0000_0000;
      if (setup && !PWRITE && hit(PADDR, wdsl_pkg::CTRL_OFFSET)) begin
         next_prdata = {24'h00_0000, ctrl_view};
      end else if (setup && !PWRITE && hit(PADDR, wdsl_pkg::COUNT_OFFSET)) begin
         next_prdata = {11'h000, count};
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end else begin
         PREADY <= next_pready;
         PSLVERR <= next_pslverr;
         PRDATA <= next_prdata;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   sequence s_unlock_write;
      wr_unlock;
   endsequence

   sequence s_window_held;
      unlock_open [*4];
   endsequence

   chk_unlock_window: assert property (
      s_unlock_write |=> s_window_held)
      else $error("unlock window shorter than four cycles");

   chk_unlock_closes: assert property (
      (unlock_cnt == 3'h1 && !wr_unlock) |=> !unlock_open)
      else $error("unlock window failed to close");

   chk_restart_clears: assert property (
      (RESTART_INSTR && enable) |=> count == 21'h00_0000)
      else $error("restart did not clear counter");

   chk_disabled_zero: assert property (
      !enable |-> count == 21'h00_0000)
      else $error("counter runs while disabled");

   chk_reset_pulse: assert property (
      CHIP_RESET |=> !CHIP_RESET)
      else $error("chip reset longer than one cycle");

   chk_timeout_cause: assert property (
      CHIP_RESET |-> $past(enable && tick && count == period_limit(period)))
      else $error("chip reset without expiry");

   chk_level2_on: assert property (
      level == wdsl_pkg::LEVEL_2 |-> enable)
      else $error("watchdog off at level 2");

   chk_disable_unlock: assert property (
      $fell(enable) |-> $past(unlock_open && wr_ctrl))
      else $error("disable without unlock");

   chk_enable_free: assert property (
      (wr_ctrl && w_enable) |=> enable)
      else $error("enable write not honoured");

   chk_level0_period: assert property (
      (wr_ctrl && level == wdsl_pkg::LEVEL_0) |=> period == $past(wbyte[2:0]))
      else $error("period not taken at level 0");

   chk_locked_period: assert property (
      (level != wdsl_pkg::LEVEL_0 && $changed(period)) |->
         $past(wr_ctrl && unlock_open && !w_unlock))
      else $error("period changed outside timed sequence");

   chk_reserved_zero: assert property (
      PREADY |-> PRDATA[7:5] == 3'h0)
      else $error("reserved bits read non-zero");

   chk_tick_spacing: assert property (
      tick |=> !tick [*8])
      else $error("oscillator tick too frequent");

endmodule

// file: verif/wdsl_watchdog_tb.sv
// Testbench for the watchdog timer with fuse safety levels
`timescale 1ns/1ps
module wdsl_watchdog_tb;
   // ---------------------------------------------------------------
   // Signals and design instance
   // ---------------------------------------------------------------
   localparam int BASE = 4;
   logic REF_CLK = 1'b0;
   logic RESET = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic RESTART_INSTR = 1'b0;
   logic LEGACY_COMPAT_FUSE = 1'b0;
   logic ALWAYS_ON_FUSE = 1'b0;
   logic CHIP_RESET;
   logic [31:0] rdata;
   logic rerr;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;

   wdsl_watchdog #(.BASE_PERIOD(BASE)) wdsl_watchdog_i (
      .REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .RESTART_INSTR(RESTART_INSTR), .LEGACY_COMPAT_FUSE(LEGACY_COMPAT_FUSE),
      .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE), .CHIP_RESET(CHIP_RESET));

   always #5 REF_CLK = ~REF_CLK;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under this many cycles
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         $display("[ERR] t=%0t cycles=%h exp=%h", $time, cycles, 30000);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic do_reset(input logic compat, input logic aon);
      @(posedge REF_CLK);
      LEGACY_COMPAT_FUSE <= compat;
      ALWAYS_ON_FUSE <= aon;
      RESET <= 1'b1;
      repeat (5) @(posedge REF_CLK);
      RESET <= 1'b0;
   endtask

   // Signals move just after a rising edge; ready and read data are taken at the edge itself
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      @(posedge REF_CLK);
      while (PREADY !== 1'b1 && n < 20) begin
         @(posedge REF_CLK);
         n++;
      end
      if (n == 20) begin
         err_total++;
         $display("[ERR] t=%0t pready=%h exp=%h", $time, PREADY, 1'b1);
      end
      rdata = PRDATA;
      rerr = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata, exp);
   endtask

   // Waits for the reset pulse and checks when it comes and that it lasts one cycle
   task automatic wait_expiry(input int lo, input int hi);
      int n;
      n = 0;
      while (CHIP_RESET !== 1'b1 && n < hi + 50) begin
         @(negedge REF_CLK);
         n++;
      end
      chk({31'h0, (n >= lo && n <= hi)}, 32'h0000_0001);
      @(negedge REF_CLK);
      chk({31'h0, CHIP_RESET}, 32'h0000_0000);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic level1_sequences();
      do_reset(1'b0, 1'b0);
      rd_chk(12'h000, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_00E3);
      rd_chk(12'h000, 32'h0000_0000);
      apb(1'b1, 12'h000, 32'h0000_0008);
      apb(1'b1, 12'h000, 32'h0000_0000);
      rd_chk(12'h000, 32'h0000_0008);
      apb(1'b1, 12'h000, 32'h0000_0018);
      // Long enough for at least one oscillator tick, short of the first expiry
      repeat (120) @(posedge REF_CLK);
      apb(1'b1, 12'h000, 32'h0000_0002);
      rd_chk(12'h000, 32'h0000_0008);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk({31'h0, rdata != 32'h0000_0000}, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0018);
      apb(1'b1, 12'h000, 32'h0000_0001);
      rd_chk(12'h000, 32'h0000_0001);
      rd_chk(12'h004, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h0000_0001);
   endtask

   task automatic restart_and_expiry();
      int i;
      do_reset(1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0008);
      for (i = 0; i < 1200; i++) begin
         @(posedge REF_CLK);
         RESTART_INSTR <= (i % 150 == 0);
         @(negedge REF_CLK);
         if (CHIP_RESET !== 1'b0) chk({31'h0, CHIP_RESET}, 32'h0000_0000);
      end
      // A last restart so the expiry window is measured from a known point
      @(posedge REF_CLK);
      RESTART_INSTR <= 1'b1;
      @(posedge REF_CLK);
      RESTART_INSTR <= 1'b0;
      wait_expiry(BASE * 100 - 110, BASE * 100 + 10);
   endtask

   task automatic level2_and_level0();
      do_reset(1'b1, 1'b1);
      rd_chk(12'h000, 32'h0000_0008);
      apb(1'b1, 12'h000, 32'h0000_0018);
      apb(1'b1, 12'h000, 32'h0000_0001);
      rd_chk(12'h000, 32'h0000_0009);
      do_reset(1'b1, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0009);
      rd_chk(12'h000, 32'h0000_0009);
      wait_expiry(BASE * 200 - 200, BASE * 200 + 10);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      level1_sequences();
      restart_and_expiry();
      level2_and_level0();
      test_done();
   end
endmodule
